// >>> core/conn_test.sv
/*
  Board link check mode of an x16 memory device: mode control and xor network.
  Assumes pins arrive asynchronously; the weak pull-down on the enable pad
  lives in the pad ring, so a floating enable reads low here.
*/
`default_nettype none
module conn_test (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ten,
  input wire logic i_cs_n,
  input wire logic [16:0] i_addr,
  input wire logic [1:0] i_ba,
  input wire logic i_bg0,
  input wire logic i_act_n,
  input wire logic i_cke,
  input wire logic i_odt,
  input wire logic i_ck,
  input wire logic i_ck_n,
  input wire logic i_par,
  input wire logic i_ldm_n,
  input wire logic i_udm_n,
  input wire logic i_alert_n,
  input wire logic i_reset_n,
  input wire logic [15:0] i_norm_dq,
  input wire logic [15:0] i_norm_dq_oe_n,
  input wire logic [3:0] i_norm_dqs,
  input wire logic [3:0] i_norm_dqs_oe_n,
  input wire logic i_norm_odt_en,
  input wire logic i_norm_refresh,
  output logic [15:0] o_dq,
  output logic [15:0] o_dq_oe_n,
  output logic [3:0] o_dqs,
  output logic [3:0] o_dqs_oe_n,
  output logic o_test_active,
  output logic o_vrefdq_force_half,
  output logic o_odt_en,
  output logic o_refresh_en,
  output logic o_clk_ignore
);
  pin_sync_if #(.W(conn_test_pkg::SYNC_W)) sif ();

  // pin order: ten, cs, addr, ba, bg0, act, cke, odt, ck, ck_n, par, ldm, udm, alert, reset
  assign sif.raw = {
    i_ten,
    i_cs_n,
    i_addr,
    i_ba,
    i_bg0,
    i_act_n,
    i_cke,
    i_odt,
    i_ck,
    i_ck_n,
    i_par,
    i_ldm_n,
    i_udm_n,
    i_alert_n,
    i_reset_n
  };

  pin_sync #(.W(conn_test_pkg::SYNC_W)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .p(sif)
  );

  logic ten_s;
  logic cs_n_s;
  logic bg0_s;
  logic act_n_s;
  logic cke_s;
  logic odt_s;
  logic ck_s;
  logic ck_n_s;
  logic par_s;
  logic ldm_n_s;
  logic udm_n_s;
  logic alert_n_s;
  logic reset_n_s;
  logic [16:0] a_s;
  logic [1:0] ba_s;
  assign {ten_s, cs_n_s, a_s, ba_s, bg0_s, act_n_s, cke_s, odt_s,
          ck_s, ck_n_s, par_s, ldm_n_s, udm_n_s, alert_n_s, reset_n_s} = sif.sync;

  // mode control
  conn_test_pkg::mode_t mode_q;
  conn_test_pkg::mode_t mode_d;
  logic [conn_test_pkg::CNT_W-1:0] cnt_q;
  logic [conn_test_pkg::CNT_W-1:0] cnt_d;

  always_comb begin
    mode_d = mode_q;
    cnt_d = cnt_q;
    case (mode_q)
      conn_test_pkg::ST_NORMAL: begin
        cnt_d = conn_test_pkg::CNT_RESET;
        if (ten_s) begin
          mode_d = conn_test_pkg::ST_ENTRY;
        end
      end
      conn_test_pkg::ST_ENTRY: begin
        if (!ten_s) begin
          mode_d = conn_test_pkg::ST_NORMAL;
        end else if (cnt_q == conn_test_pkg::CNT_W'(conn_test_pkg::ENTRY_CYCLES - 1)) begin
          mode_d = conn_test_pkg::ST_TEST;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      conn_test_pkg::ST_TEST: begin
        if (!ten_s) begin
          mode_d = conn_test_pkg::ST_NORMAL;
        end
      end
      default: begin
        mode_d = conn_test_pkg::ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mode_q <= conn_test_pkg::ST_NORMAL;
      cnt_q <= conn_test_pkg::CNT_RESET;
    end else begin
      mode_q <= mode_d;
      cnt_q <= cnt_d;
    end
  end

  // xor network on all pins except cs, at once
  logic [conn_test_pkg::MINTERMS-1:0] mt;
  always_comb begin
    mt[0] = a_s[1] ^ a_s[6] ^ par_s;
    mt[1] = a_s[8] ^ alert_n_s ^ a_s[9];
    mt[2] = a_s[2] ^ a_s[5] ^ a_s[13];
    mt[3] = a_s[0] ^ a_s[7] ^ a_s[11];
    mt[4] = ck_n_s ^ odt_s ^ a_s[15];
    mt[5] = cke_s ^ a_s[16] ^ a_s[10];
    mt[6] = act_n_s ^ a_s[4] ^ ba_s[1];
    mt[7] = udm_n_s ^ ldm_n_s ^ ck_s;
    mt[8] = a_s[14] ^ a_s[12] ^ ba_s[0];
    mt[9] = bg0_s ^ a_s[3] ^ reset_n_s ^ ten_s;
  end

  logic in_test;
  assign in_test = (mode_q == conn_test_pkg::ST_TEST);

  // output stage
  logic [15:0] dq_q;
  logic [15:0] dq_d;
  logic [15:0] dq_oe_n_q;
  logic [15:0] dq_oe_n_d;
  logic [3:0] dqs_q;
  logic [3:0] dqs_d;
  logic [3:0] dqs_oe_n_q;
  logic [3:0] dqs_oe_n_d;
  logic act_q;
  logic act_d;
  logic vref_q;
  logic vref_d;
  logic odt_q;
  logic odt_d;
  logic ref_q;
  logic ref_d;
  logic ckig_q;
  logic ckig_d;

  always_comb begin
    dq_d = i_norm_dq;
    dq_oe_n_d = i_norm_dq_oe_n;
    dqs_d = i_norm_dqs;
    dqs_oe_n_d = i_norm_dqs_oe_n;
    odt_d = i_norm_odt_en;
    ref_d = i_norm_refresh;
    act_d = in_test;
    vref_d = in_test;
    ckig_d = (mode_q != conn_test_pkg::ST_NORMAL);
    if (mode_q != conn_test_pkg::ST_NORMAL) begin
      odt_d = 1'b0;
      ref_d = 1'b0;
    end
    if (in_test) begin
      dq_d = {~mt[7:0], mt[7:0]};
      dqs_d = {~mt[9], ~mt[8], mt[9], mt[8]};
      dq_oe_n_d = {16{cs_n_s}};
      dqs_oe_n_d = {4{cs_n_s}};
    end else if (mode_q == conn_test_pkg::ST_ENTRY) begin
      dq_oe_n_d = conn_test_pkg::DQ_OE_RESET;
      dqs_oe_n_d = conn_test_pkg::DQS_OE_RESET;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      dq_q <= conn_test_pkg::DQ_RESET;
      dq_oe_n_q <= conn_test_pkg::DQ_OE_RESET;
      dqs_q <= conn_test_pkg::DQS_RESET;
      dqs_oe_n_q <= conn_test_pkg::DQS_OE_RESET;
      act_q <= 1'b0;
      vref_q <= 1'b0;
      odt_q <= 1'b0;
      ref_q <= 1'b0;
      ckig_q <= 1'b0;
    end else begin
      dq_q <= dq_d;
      dq_oe_n_q <= dq_oe_n_d;
      dqs_q <= dqs_d;
      dqs_oe_n_q <= dqs_oe_n_d;
      act_q <= act_d;
      vref_q <= vref_d;
      odt_q <= odt_d;
      ref_q <= ref_d;
      ckig_q <= ckig_d;
    end
  end

  assign o_dq = dq_q;
  assign o_dq_oe_n = dq_oe_n_q;
  assign o_dqs = dqs_q;
  assign o_dqs_oe_n = dqs_oe_n_q;
  assign o_test_active = act_q;
  assign o_vrefdq_force_half = vref_q;
  assign o_odt_en = odt_q;
  assign o_refresh_en = ref_q;
  assign o_clk_ignore = ckig_q;
endmodule
`default_nettype wire

// >>> core/conn_test_pkg.sv
/*
  Constants and types for the board link check logic of an x16 memory device.
  Assumes a single 200 MHz system clock and a synchronous active-high reset.
*/
// Summary of operation
// - test enable high: pins become parallel test inputs and test outputs
// - in test mode the internal data reference is forced to half supply
// - test outputs driven only with chip select low, otherwise released
// - all on-die termination off for the whole test mode
// - clock pins ignored; entry completes after at least 200 ns
// - outputs settle within 200 ns of applied test inputs
// - all inputs but chip select taken at once and evaluated as a parallel xor network
// - no array refresh, external or self, while in test mode
// - test enable may fall any time; state afterwards is undefined
// - test enable pin weakly pulled low so a floating pin stays idle
// - minterms 0 to 3 are xor of their three address or control pins
// - minterms 4 to 6 are xor of clock, command and bank pins
// - minterm 7 masks and clock, 8 command and bank, 9 with reset and enable
// - data 0 to 7 carry minterms 0 to 7; data 8 to 15 their inverses
// - lower strobe pair carries minterms 8 and 9; upper pair their inverses
`default_nettype none
package conn_test_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TEST_ENTRY_DELAY_NS = 200;
  localparam int TEST_OUTPUT_SETTLE_TIME_NS = 200;
  // least time rounds up
  localparam int ENTRY_CYCLES = (TEST_ENTRY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // longest time rounds down
  localparam int SETTLE_CYCLES = (TEST_OUTPUT_SETTLE_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;
  localparam int MINTERMS = 10;
  localparam int SYNC_W = 32;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [15:0] DQ_OE_RESET = 16'hFFFF;
  localparam logic [15:0] DQ_RESET = 16'h0000;
  localparam logic [3:0] DQS_RESET = 4'h0;
  localparam logic [3:0] DQS_OE_RESET = 4'hF;
  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_ENTRY = 3'b010,
    ST_TEST = 3'b100
  } mode_t;
endpackage
`default_nettype wire

// >>> core/pin_sync.sv
/*
  Two-flop synchroniser for a bus of independent pin levels.
  Assumes pins are quasi-static levels; no bus coherence is given.
*/
`default_nettype none
module pin_sync #(
  parameter int W = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  pin_sync_if.sync_side p
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  always_comb begin
    meta_d = p.raw;
    sync_d = meta_q;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign p.sync = sync_q;
endmodule
`default_nettype wire

// >>> core/pin_sync_if.sv
/*
  Bundle of raw and synchronised test pins passed to and from the synchroniser module.
  Assumes one clock domain.
*/
`default_nettype none
interface pin_sync_if #(parameter int W = 32);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface
`default_nettype wire

// >>> verification/conn_test_sva.sv
/*
  assertions on the link check block ports.
  assumes one clock, synchronous active-high reset.
*/
`default_nettype none
module conn_test_sva (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ten,
  input wire logic i_cs_n,
  input wire logic [15:0] i_norm_dq,
  input wire logic [15:0] o_dq,
  input wire logic [15:0] o_dq_oe_n,
  input wire logic [3:0] o_dqs,
  input wire logic [3:0] o_dqs_oe_n,
  input wire logic o_test_active,
  input wire logic o_vrefdq_force_half,
  input wire logic o_odt_en,
  input wire logic o_refresh_en,
  input wire logic o_clk_ignore
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence cs_off_s; i_cs_n[*5]; endsequence
  sequence ten_off_s; (!i_ten)[*6]; endsequence
  rel_off_a: assert property (cs_off_s ##0 o_test_active |-> &{o_dq_oe_n, o_dqs_oe_n})
    else $error("test outputs driven with chip select high");
  dq_pair_a: assert property (o_test_active |-> o_dq[15:8] == ~o_dq[7:0])
    else $error("upper data not inverse of lower");
  dqs_pair_a: assert property (o_test_active |-> o_dqs[3:2] == ~o_dqs[1:0])
    else $error("upper strobe not inverse of lower");
  vref_half_a: assert property (o_test_active |-> o_vrefdq_force_half)
    else $error("reference not forced");
  odt_off_a: assert property (o_test_active |-> !o_odt_en)
    else $error("termination on in test");
  no_refresh_a: assert property (o_test_active |-> !o_refresh_en)
    else $error("refresh in test");
  clk_ign_a: assert property (o_test_active |-> o_clk_ignore)
    else $error("clock not ignored in test");
  entry_delay_a: assert property ($rose(o_test_active) |-> $past(o_clk_ignore, 40))
    else $error("test entry too early");
  pass_thru_a: assert property (ten_off_s |-> !o_test_active && o_dq == $past(i_norm_dq))
    else $error("normal path disturbed");
endmodule
bind conn_test conn_test_sva SVA (.*);
`default_nettype wire

// >>> verification/conn_test_tb.sv
/*
  bench for the link check block with a controller model.
  assumes the design package is compiled first.
*/
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fails++; $display("mismatch %s exp %0h got %0h", n, e, a); end end
module conn_test_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, ten = 1'b0, cs = 1'b1, i_norm_odt_en = 1'b1, i_norm_refresh = 1'b1;
  logic i_ten, i_cs_n, i_reset_n, o_test_active, o_vrefdq_force_half, o_odt_en, o_refresh_en, o_clk_ignore;
  logic [28:0] pat = 29'h0, pins;
  logic [15:0] i_norm_dq = 16'h0000, i_norm_dq_oe_n = 16'hFFFF, o_dq, o_dq_oe_n;
  logic [3:0] i_norm_dqs = 4'h5, i_norm_dqs_oe_n = 4'hA, o_dqs, o_dqs_oe_n;
  int fails = 0, compares = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  ctl_model PARTNER (.i_ten(ten), .i_cs_n(cs), .i_pat(pat), .o_ten(i_ten), .o_cs_n(i_cs_n),
    .o_pat(pins), .o_reset_n(i_reset_n));
  conn_test DUT (.*, .i_addr(pins[16:0]), .i_ba(pins[18:17]), .i_bg0(pins[19]), .i_act_n(pins[20]),
    .i_cke(pins[21]), .i_odt(pins[22]), .i_ck(pins[23]), .i_ck_n(pins[24]), .i_par(pins[25]),
    .i_ldm_n(pins[26]), .i_udm_n(pins[27]), .i_alert_n(pins[28]));
  function automatic logic [19:0] exp_out(input logic [28:0] p);
    logic [9:0] m;
    m[0] = p[1] ^ p[6] ^ p[25];
    m[1] = p[8] ^ p[28] ^ p[9];
    m[2] = p[2] ^ p[5] ^ p[13];
    m[3] = p[0] ^ p[7] ^ p[11];
    m[4] = p[24] ^ p[22] ^ p[15];
    m[5] = p[21] ^ p[16] ^ p[10];
    m[6] = p[20] ^ p[4] ^ p[18];
    m[7] = p[27] ^ p[26] ^ p[23];
    m[8] = p[14] ^ p[12] ^ p[17];
    m[9] = p[19] ^ p[3] ^ 1'b1 ^ 1'b1;
    return {~m[9], ~m[8], m[9], m[8], ~m[7:0], m[7:0]};
  endfunction
  task automatic step(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_norm;
    i_norm_dq = 16'h3C5A;
    i_norm_dq_oe_n = 16'h00F0;
    step(3);
    `CHK("dq", 16'h3C5A, o_dq)
    `CHK("oe", 16'h00F0, o_dq_oe_n)
    `CHK("odt", 1'b1, o_odt_en)
    `CHK("dqs", 4'h5, o_dqs)
    `CHK("dqs oe", 4'hA, o_dqs_oe_n)
    `CHK("refresh", 1'b1, o_refresh_en)
    `CHK("ignore", 1'b0, o_clk_ignore)
    $display("normal test done");
  endtask
  task automatic t_entry;
    int n;
    ten = 1'b1;
    cs = 1'b0;
    step(6);
    `CHK("ignore", 1'b1, o_clk_ignore)
    `CHK("oe", 16'hFFFF, o_dq_oe_n)
    n = 6;
    while (o_test_active !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    if (n >= 200) begin
      fails++;
      results();
    end
    `CHK("delay", 1'b1, n >= 40)
    `CHK("vref", 1'b1, o_vrefdq_force_half)
    `CHK("odt", 1'b0, o_odt_en)
    `CHK("refresh", 1'b0, o_refresh_en)
    $display("entry test done");
  endtask
  task automatic t_xor;
    logic [19:0] e;
    for (int i = 0; i < 30; i++) begin
      pat = (i < 29) ? (29'h1 << i) : 29'h0;
      e = exp_out(pat);
      step(conn_test_pkg::SETTLE_CYCLES);
      `CHK("dq", e[15:0], o_dq)
      `CHK("dqs", e[19:16], o_dqs)
      `CHK("oe", 20'h00000, {o_dqs_oe_n, o_dq_oe_n})
    end
    $display("xor test done");
  endtask
  task automatic t_cs_exit;
    cs = 1'b1;
    step(40);
    `CHK("oe", 20'hFFFFF, {o_dqs_oe_n, o_dq_oe_n})
    cs = 1'b0;
    ten = 1'b0;
    step(40);
    `CHK("active", 1'b0, o_test_active)
    `CHK("dq", i_norm_dq, o_dq)
    `CHK("oe", 16'h00F0, o_dq_oe_n)
    `CHK("ignore", 1'b0, o_clk_ignore)
    $display("chip select and exit test done");
  endtask
  task automatic t_abort;
    ten = 1'b1;
    step(10);
    `CHK("ignore", 1'b1, o_clk_ignore)
    `CHK("oe", 16'hFFFF, o_dq_oe_n)
    ten = 1'b0;
    step(6);
    `CHK("ignore", 1'b0, o_clk_ignore)
    `CHK("active", 1'b0, o_test_active)
    `CHK("dq", 16'h3C5A, o_dq)
    $display("entry abort test done");
  endtask
  initial begin
    step(4);
    i_rst = 1'b0;
    t_norm();
    t_entry();
    t_xor();
    t_cs_exit();
    i_rst = 1'b1;
    step(4);
    i_rst = 1'b0;
    t_norm();
    t_abort();
    results();
  end
endmodule
`default_nettype wire

// >>> verification/ctl_model.sv
/*
  controller side model driving the test pins.
  assumes requests change at the clock fall.
*/
`default_nettype none
module ctl_model (
  input wire logic i_ten,
  input wire logic i_cs_n,
  input wire logic [28:0] i_pat,
  output logic o_ten,
  output logic o_cs_n,
  output logic [28:0] o_pat,
  output logic o_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_reset_n = 1'b1;
  assign o_ten = i_ten;
  assign o_cs_n = i_cs_n;
  assign o_pat = i_pat;
endmodule
`default_nettype wire
